/* verilog/data_memory_pkg.sv */
// Purpose: Shared constants and carriers for the banked data memory addressing block.
// Assumes: 12-bit data address, 16 banks of 256 bytes, one access per clock.
// Notes: Offsets are byte addresses within data memory.
package data_memory_pkg;
    // ==========================================================
    // Geometry
    localparam int ADDR_W = 12;
    localparam int OFFSET_W = 8;
    localparam int BANK_W = 4;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 4096;
    localparam logic [4:0] NUM_BANKS = 5'h10;

    // ==========================================================
    // Access bank map and fixed addresses
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [11:0] BANK_POINTER_ADDR = 12'hfe0;
    localparam logic [11:0] PC_LOW_BYTE_ADDR = 12'hff9;
    localparam logic [3:0] BANK_POINTER_RESET = 4'h0;
    localparam logic [3:0] BANK_POINTER_UNUSED = 4'h0;

    // ==========================================================
    // Requests from the execute stage
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_WRITE = 3'h3,
        OP_MOVE = 3'h2,
        OP_LOAD_BANK = 3'h6
    } op_e;

    typedef struct packed {
        op_e op;
        logic map_sel;
        logic [7:0] offset;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
        logic [7:0] wdata;
        logic [7:0] literal;
    } mem_req_s;
endpackage

/* verilog/bank_addr_resolve.sv */
// Purpose: Forms a 12-bit data address from an 8-bit operand offset.
// Assumes: Pure combinational; the caller registers whatever it needs.
// Notes: The alternate map of the extended set is flagged, not resolved.
`timescale 1ns/1ps
`default_nettype none
module bank_addr_resolve (
    input wire logic map_sel,
    input wire logic [7:0] offset,
    input wire logic [3:0] bank,
    input wire logic extended_set_config,
    output logic [11:0] addr,
    output logic alt_map
);
    import data_memory_pkg::*;

    wire logic [11:0] banked_addr;
    wire logic [11:0] access_addr;

    assign banked_addr = {bank, offset};
    assign access_addr = (offset < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, offset}
                                                 : {ACCESS_HIGH_BANK, offset};
    assign addr = map_sel ? banked_addr : access_addr;
    assign alt_map = !map_sel && extended_set_config;
endmodule
`default_nettype wire

/* verilog/data_memory_access.sv */
// Purpose: Banked data memory with bank pointer and access-bank addressing.
// Assumes: One request per clock from the execute stage, same clock domain.
// Notes: Storage is flip-flops; read data is registered one cycle after the request.
//
// Behaviour
// - Every data byte has a 12-bit address, 4,096 bytes in all.
// - Data space is 16 banks of 256 bytes, populated only below POPULATED_BANKS (all 16 by default).
// - Reading a location without storage returns zero.
// - Banked address is bank pointer as top 4 bits, then 8-bit offset.
// - Bank pointer keeps bits 3:0 only; upper bits read zero, ignore writes.
// - Load-bank-literal op writes an immediate into the bank pointer.
// - Unpopulated bank: writes dropped and reads zero (bank pointer at FE0h excepted), status still updates.
// - Full-address move uses 12-bit source and destination, ignores bank pointer.
// - Other accesses give 8-bit offset, resolved by bank pointer or access map.
// - Access map: 00h-5Fh to bank 0, 60h-FFh to bank 15.
// - Map select 1 uses bank pointer plus operand offset.
// - Map select 0 uses access map, ignoring bank pointer, unless extended set config flags it as an alternate-map request.
// - Access-map access completes in one cycle, no bank update needed.
// - Bank 0Fh, offset F9h write reaches the pc low byte.
`timescale 1ns/1ps
`default_nettype none
module data_memory_access #(
    parameter logic [4:0] POPULATED_BANKS = data_memory_pkg::NUM_BANKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire data_memory_pkg::mem_req_s req,
    input wire logic extended_set_config,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic status_update,
    output logic alt_map_request,
    output logic [11:0] last_addr,
    output logic pc_low_write,
    output logic [7:0] pc_low_data,
    output logic [7:0] bank_pointer_view
);
    import data_memory_pkg::*;

    // ==========================================================
    // State
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [3:0] bank_pointer;

    // ==========================================================
    // Address formation
    wire logic [11:0] operand_addr;
    wire logic alt_map;
    wire logic is_read;
    wire logic is_write;
    wire logic is_move;
    wire logic is_load;
    wire logic offset_op;
    wire logic [11:0] rd_addr;
    wire logic [11:0] wr_addr;
    wire logic [7:0] wr_value;
    wire logic wr_en;
    wire logic rd_populated;
    wire logic wr_populated;
    wire logic [7:0] rd_value;
    wire logic [7:0] bank_read_value;

    bank_addr_resolve u_resolve (
        .map_sel(req.map_sel),
        .offset(req.offset),
        .bank(bank_pointer),
        .extended_set_config(extended_set_config),
        .addr(operand_addr),
        .alt_map(alt_map)
    );

    assign is_read = (req.op == OP_READ);
    assign is_write = (req.op == OP_WRITE);
    assign is_move = (req.op == OP_MOVE);
    assign is_load = (req.op == OP_LOAD_BANK);
    assign offset_op = (is_read || is_write) && !alt_map;

    // The move carries both addresses in full; the bank pointer takes no part.
    assign rd_addr = is_move ? req.src_addr : operand_addr;
    assign wr_addr = is_move ? req.dst_addr : operand_addr;
    assign wr_en = is_move || (is_write && !alt_map);

    assign rd_populated = {1'b0, rd_addr[11:8]} < POPULATED_BANKS;
    assign wr_populated = {1'b0, wr_addr[11:8]} < POPULATED_BANKS;

    assign bank_read_value = {BANK_POINTER_UNUSED, bank_pointer};
    assign rd_value = (rd_addr == BANK_POINTER_ADDR) ? bank_read_value
                    : rd_populated ? mem[rd_addr] : 8'h00;
    assign wr_value = is_move ? rd_value : req.wdata;

    // ==========================================================
    // Bank pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_pointer <= BANK_POINTER_RESET;
        end else if (is_load) begin
            bank_pointer <= req.literal[3:0];
        end else if (wr_en && wr_addr == BANK_POINTER_ADDR) begin
            bank_pointer <= wr_value[3:0];
        end
    end

    // ==========================================================
    // Storage; contents are not cleared by reset.
    always_ff @(posedge clk) begin
        if (wr_en && wr_populated && wr_addr != BANK_POINTER_ADDR) begin
            mem[wr_addr] <= wr_value;
        end
    end

    // ==========================================================
    // Answers to the execute stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
            status_update <= 1'b0;
            alt_map_request <= 1'b0;
            last_addr <= 12'h000;
            pc_low_write <= 1'b0;
            pc_low_data <= 8'h00;
        end else begin
            rdata <= ((is_read && !alt_map) || is_move) ? rd_value : 8'h00;
            rdata_valid <= is_read && !alt_map;
            status_update <= offset_op;
            alt_map_request <= (is_read || is_write) && alt_map;
            last_addr <= wr_addr;
            pc_low_write <= wr_en && wr_addr == PC_LOW_BYTE_ADDR;
            pc_low_data <= wr_value;
        end
    end

    assign bank_pointer_view = bank_read_value;

    // ==========================================================
    // Checks
    sequence load_seen;
        req.op == OP_LOAD_BANK;
    endsequence

    sequence access_read(logic sel);
        req.op == OP_READ && req.map_sel == sel && !extended_set_config;
    endsequence

    bank_load_a: assert property (@(posedge clk) disable iff (rst)
        load_seen |=> bank_pointer == $past(req.literal[3:0]))
        else $error("bank pointer did not take the loaded literal");

    bank_upper_a: assert property (@(posedge clk) disable iff (rst)
        bank_pointer_view[7:4] == 4'h0)
        else $error("bank pointer upper bits not zero");

    banked_addr_a: assert property (@(posedge clk) disable iff (rst)
        access_read(1'b1) |=> last_addr == {$past(bank_pointer), $past(req.offset)})
        else $error("banked address not formed from bank pointer");

    access_low_a: assert property (@(posedge clk) disable iff (rst)
        access_read(1'b0) and req.offset < 8'h60 |=> last_addr[11:8] == 4'h0)
        else $error("low access map offset not in bank 0");

    access_high_a: assert property (@(posedge clk) disable iff (rst)
        access_read(1'b0) and req.offset >= 8'h60 |=> last_addr == {4'hf, $past(req.offset)})
        else $error("high access map offset not in bank 15");

    move_addr_a: assert property (@(posedge clk) disable iff (rst)
        req.op == OP_MOVE |=> last_addr == $past(req.dst_addr))
        else $error("move destination not taken in full");

    access_single_a: assert property (@(posedge clk) disable iff (rst)
        access_read(1'b0) |=> rdata_valid && status_update)
        else $error("access map read did not finish in one cycle");

    pc_low_a: assert property (@(posedge clk) disable iff (rst)
        req.op == OP_WRITE && req.map_sel && bank_pointer == 4'hf && req.offset == 8'hf9
        |=> pc_low_write && pc_low_data == $past(req.wdata))
        else $error("banked write to pc low byte not forwarded");

    alt_map_a: assert property (@(posedge clk) disable iff (rst)
        req.op == OP_READ && !req.map_sel && extended_set_config |=> alt_map_request && !rdata_valid)
        else $error("extended set access not handed off");

    empty_zero_a: assert property (@(posedge clk) disable iff (rst)
        is_read && !alt_map && !rd_populated && rd_addr != BANK_POINTER_ADDR |=> rdata == 8'h00)
        else $error("unpopulated read returned nonzero");

    sequence bank_reg_write;
        wr_en && wr_addr == BANK_POINTER_ADDR;
    endsequence

    sequence handled_write;
        req.op == OP_WRITE && !(extended_set_config && !req.map_sel);
    endsequence

    bank_write_a: assert property (@(posedge clk) disable iff (rst)
        bank_reg_write |=> bank_pointer_view == {4'h0, $past(wr_value[3:0])})
        else $error("bank pointer write not masked to four bits");

    write_status_a: assert property (@(posedge clk) disable iff (rst)
        handled_write |=> status_update && !rdata_valid && rdata == 8'h00)
        else $error("write did not update status alone");

    alt_write_a: assert property (@(posedge clk) disable iff (rst)
        req.op == OP_WRITE && !req.map_sel && extended_set_config
        |=> alt_map_request && !status_update && !pc_low_write)
        else $error("extended set write not handed off");

    move_data_a: assert property (@(posedge clk) disable iff (rst)
        req.op == OP_MOVE && rd_populated && req.src_addr != BANK_POINTER_ADDR
        |=> rdata == $past(mem[req.src_addr]))
        else $error("move did not return the full-address source byte");

    read_idle_a: assert property (@(posedge clk) disable iff (rst)
        req.op != OP_MOVE && !(is_read && !alt_map) |=> rdata == 8'h00 && !rdata_valid)
        else $error("read data not cleared after a non-read request");

    pc_low_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_en && wr_addr == PC_LOW_BYTE_ADDR) |=> !pc_low_write)
        else $error("pc low byte write flagged without a write");

    load_quiet_a: assert property (@(posedge clk) disable iff (rst)
        load_seen |=> !status_update && !rdata_valid && !alt_map_request)
        else $error("bank load touched the data path");
endmodule
`default_nettype wire

/* bench/exec_stage_model.sv */
// Purpose: Execute-stage model that hands one data request to the memory block.
// Assumes: Requests change on the falling edge, away from the sampling edge.
// Notes: Each request stands for one clock, then the stage goes idle.
`timescale 1ns/1ps
`default_nettype none
module exec_stage_model (
    input wire logic clk,
    output var data_memory_pkg::mem_req_s req
);
    import data_memory_pkg::*;
    initial req = '0;
    // ==========================================================
    // Request issue
    // The literal field carries the data byte as well, for the bank load.
    task automatic send(input op_e op, input logic sel, input logic [7:0] off, input logic [7:0] wd,
                        input logic [11:0] src, input logic [11:0] dst);
        @(negedge clk);
        req <= '{op: op, map_sel: sel, offset: off, src_addr: src, dst_addr: dst, wdata: wd, literal: wd};
        @(negedge clk);
        req <= '0;
    endtask
endmodule
`default_nettype wire

/* bench/banked_data_memory_addressing_bench.sv */
// Purpose: Self-checking bench for the banked data memory block.
// Assumes: Only banks 0 to 3 hold storage in this build.
// Notes: Results are checked one clock after each request.
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_addressing_bench;
    import data_memory_pkg::*;
    typedef struct packed {op_e op; logic sel; logic [7:0] off; logic [7:0] wd; logic [7:0] rd; logic [11:0] a;} row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic xcfg = 1'b0;
    mem_req_s req;
    logic [7:0] rdata, pc_data, bview;
    logic [11:0] last_addr;
    logic rvalid, status, alt, pcw;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    row_s rows [12] = '{
        '{OP_LOAD_BANK, 1'b0, 8'h00, 8'hf3, 8'h00, 12'h000}, '{OP_WRITE, 1'b1, 8'h22, 8'ha5, 8'h00, 12'h322},
        '{OP_READ, 1'b1, 8'h22, 8'h00, 8'ha5, 12'h322}, '{OP_WRITE, 1'b0, 8'h22, 8'h5a, 8'h00, 12'h022},
        '{OP_READ, 1'b0, 8'h22, 8'h00, 8'h5a, 12'h022}, '{OP_READ, 1'b1, 8'h22, 8'h00, 8'ha5, 12'h322},
        '{OP_WRITE, 1'b0, 8'h5f, 8'hc3, 8'h00, 12'h05f}, '{OP_READ, 1'b0, 8'h5f, 8'h00, 8'hc3, 12'h05f},
        '{OP_WRITE, 1'b0, 8'h60, 8'h11, 8'h00, 12'hf60}, '{OP_LOAD_BANK, 1'b0, 8'h00, 8'h05, 8'h00, 12'h000},
        '{OP_WRITE, 1'b1, 8'h10, 8'h77, 8'h00, 12'h510}, '{OP_READ, 1'b1, 8'h10, 8'h00, 8'h00, 12'h510}};
    always #4 clk = ~clk;
    exec_stage_model model_u (.clk(clk), .req(req));
    data_memory_access #(.POPULATED_BANKS(5'h04)) dut_u (.clk(clk), .rst(rst), .req(req),
        .extended_set_config(xcfg), .rdata(rdata), .rdata_valid(rvalid), .status_update(status),
        .alt_map_request(alt), .last_addr(last_addr), .pc_low_write(pcw), .pc_low_data(pc_data),
        .bank_pointer_view(bview));
    // ==========================================================
    // Checking and closing
    task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({11'h000, got}, {11'h000, exp});
    endtask
    task automatic stop_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ==========================================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp_val({4'h0, bview}, 12'h000);
        cmp_val({4'h0, rdata}, 12'h000);
        foreach (rows[i]) begin
            model_u.send(rows[i].op, rows[i].sel, rows[i].off, rows[i].wd, 12'h000, 12'h000);
            cmp_val({4'h0, rdata}, {4'h0, rows[i].rd});
            cmp_bit(rvalid, rows[i].op == OP_READ);
            cmp_bit(status, rows[i].op == OP_READ || rows[i].op == OP_WRITE);
            if (rows[i].op != OP_LOAD_BANK) begin
                cmp_val(last_addr, rows[i].a);
            end
        end
        model_u.send(OP_LOAD_BANK, 1'b0, 8'h00, 8'hff, 12'h000, 12'h000);
        cmp_val({4'h0, bview}, 12'h00f);
        model_u.send(OP_WRITE, 1'b1, 8'hf9, 8'h3c, 12'h000, 12'h000);
        cmp_bit(pcw, 1'b1);
        cmp_val({4'h0, pc_data}, 12'h03c);
        cmp_val(last_addr, 12'hff9);
        model_u.send(OP_MOVE, 1'b1, 8'h00, 8'h00, 12'h322, 12'h050);
        cmp_val({4'h0, rdata}, 12'h0a5);
        cmp_val(last_addr, 12'h050);
        model_u.send(OP_READ, 1'b0, 8'h50, 8'h00, 12'h000, 12'h000);
        cmp_val({4'h0, rdata}, 12'h0a5);
        xcfg = 1'b1;
        model_u.send(OP_READ, 1'b0, 8'h22, 8'h00, 12'h000, 12'h000);
        cmp_bit(alt, 1'b1);
        cmp_bit(rvalid, 1'b0);
        model_u.send(OP_WRITE, 1'b0, 8'h22, 8'h99, 12'h000, 12'h000);
        cmp_bit(alt, 1'b1);
        cmp_bit(status, 1'b0);
        xcfg = 1'b0;
        model_u.send(OP_READ, 1'b0, 8'h22, 8'h00, 12'h000, 12'h000);
        cmp_val({4'h0, rdata}, 12'h05a);
        model_u.send(OP_MOVE, 1'b0, 8'h00, 8'h00, 12'h322, 12'hfe0);
        cmp_val({4'h0, bview}, 12'h005);
        cmp_bit(pcw, 1'b0);
        model_u.send(OP_READ, 1'b0, 8'he0, 8'h00, 12'h000, 12'h000);
        cmp_val({4'h0, rdata}, 12'h005);
        // A second reset in mid-run clears the bank pointer but keeps the stored bytes.
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        cmp_val({4'h0, bview}, 12'h000);
        cmp_val(last_addr, 12'h000);
        cmp_bit(rvalid, 1'b0);
        rst = 1'b0;
        model_u.send(OP_READ, 1'b0, 8'h5f, 8'h00, 12'h000, 12'h000);
        cmp_val({4'h0, rdata}, 12'h0c3);
        stop_test();
    end
endmodule
`default_nettype wire
